// >>> core/sacs_top.sv
// serial conversion sequencer: control byte intake, track/hold timing, sar and result shift-out
// assumes serial pins are asynchronous to clk and the serial clock is well below 10 MHz
`timescale 1ns/1ps
`include "sacs_defines.svh"
module sacs_top (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  din,
    input  wire logic                  shutdown_n,
    input  wire logic                  comparator,
    output logic                       dout,
    output logic                       dout_oe,
    output logic                       conversion_strobe,
    output logic                       conversion_strobe_oe,
    output sacs_pkg::sacs_analog_t     analog_ctrl
);

    // two-flop synchronisers; only the second stage and the edge delay are read
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic       sclk_d_ff;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_ff   <= 5'h02;
            sync_ff   <= 5'h02;
            sclk_d_ff <= 1'b0;
        end else begin
            meta_ff   <= {comparator, shutdown_n, din, cs_n, sclk};
            sync_ff   <= meta_ff;
            sclk_d_ff <= sync_ff[0];
        end
    end

    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic shutdown_n_n_s;
    logic cmp_s;
    logic rise;
    logic fall;
    logic active;
    assign sclk_s   = sync_ff[0];
    assign cs_n_s   = sync_ff[1];
    assign din_s    = sync_ff[2];
    assign shutdown_n_n_s = sync_ff[3];
    assign cmp_s    = sync_ff[4];
    assign rise     = sclk_s & ~sclk_d_ff;
    assign fall     = ~sclk_s & sclk_d_ff;
    // shutdown overrides the serial port entirely
    assign active   = ~cs_n_s & shutdown_n_n_s;

    // mux decode: single-ended uses common, differential uses the fixed pair
    function automatic logic [6:0] mux_of(input logic [2:0] sel, input logic sgl);
        logic [6:0] m;
        m = 7'h00;
        if (sgl) begin
            m = {sel, 3'h0, 1'b1};
        end else begin
            m = {sel[2:1], sel[0], sel[2:1], ~sel[0], 1'b0};
        end
        return m;
    endfunction

    sacs_pkg::sacs_state_t state_ff;
    logic [4:0]            cnt_ff;
    logic [7:0]            ctrl_ff;
    logic [2:0]            sel_ff;
    logic                  sgl_ff;

    // framing state; deselect or shutdown returns to hunting for a start bit
    always_ff @(posedge clk) begin
        if (!resetn || !active) begin
            state_ff <= sacs_pkg::SACS_WAIT_START;
            cnt_ff   <= 5'h00;
            ctrl_ff  <= 8'h00;
        end else if (rise) begin
            case (state_ff)
                sacs_pkg::SACS_WAIT_START: begin
                    if (din_s) begin
                        state_ff <= sacs_pkg::SACS_CTRL;
                        cnt_ff   <= 5'h01;
                        ctrl_ff  <= 8'h01;
                    end
                end
                sacs_pkg::SACS_CTRL: begin
                    ctrl_ff <= {ctrl_ff[6:0], din_s};
                    cnt_ff  <= cnt_ff + 5'h01;
                    if (cnt_ff == `SACS_CTRL_BITS - 5'h01) begin
                        state_ff <= sacs_pkg::SACS_CONV;
                    end
                end
                sacs_pkg::SACS_CONV: begin
                    cnt_ff <= cnt_ff + 5'h01;
                    if (cnt_ff == `SACS_LAST_CNT) begin
                        state_ff <= sacs_pkg::SACS_DONE;
                    end
                end
                sacs_pkg::SACS_DONE: begin
                    cnt_ff <= cnt_ff;
                end
                default: begin
                    state_ff <= sacs_pkg::SACS_WAIT_START;
                end
            endcase
        end
    end

    // channel fields caught as their bits arrive so the mux can settle during tracking
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_ff <= 3'h0;
            sgl_ff <= 1'b1;
        end else if (rise && active && state_ff == sacs_pkg::SACS_CTRL) begin
            if (cnt_ff == `SACS_SEL_CNT) begin
                sel_ff <= {ctrl_ff[1:0], din_s};
            end
            if (cnt_ff == `SACS_SGL_CNT) begin
                sgl_ff <= din_s;
            end
        end
    end

    // front-end control flops; each has one process, the struct is only packed at the port
    logic [2:0]  pos_sel_ff;
    logic [2:0]  neg_sel_ff;
    logic        neg_com_ff;
    logic        track_ff;
    logic        hold_ff;
    logic [11:0] dac_ff;

    // track/hold and mux; acquisition is the three periods between falls 5 and 8
    always_ff @(posedge clk) begin
        if (!resetn || !active) begin
            pos_sel_ff <= 3'h0;
            neg_sel_ff <= 3'h0;
            neg_com_ff <= 1'b1;
            track_ff   <= 1'b0;
            hold_ff    <= 1'b0;
        end else if (fall && state_ff != sacs_pkg::SACS_WAIT_START) begin
            if (cnt_ff >= `SACS_TRACK_CNT && cnt_ff < `SACS_CTRL_BITS) begin
                track_ff <= 1'b1;
                {pos_sel_ff, neg_sel_ff, neg_com_ff} <= mux_of(sel_ff, sgl_ff);
            end
            if (cnt_ff == `SACS_CTRL_BITS) begin
                // open the switch and move the capacitor to the negative side in the same step
                track_ff <= 1'b0;
                hold_ff  <= 1'b1;
            end
            if (cnt_ff == `SACS_LAST_CNT) begin
                hold_ff <= 1'b0;
            end
        end
    end

    // successive approximation and result shift-out, all on serial clock rises
    logic [3:0] bit_idx;
    assign bit_idx = 4'(`SACS_LSB_CNT - cnt_ff);
    always_ff @(posedge clk) begin
        if (!resetn || !active) begin
            dout                 <= 1'b0;
            dout_oe              <= 1'b0;
            conversion_strobe    <= 1'b0;
            conversion_strobe_oe <= 1'b0;
            dac_ff               <= `SACS_ZERO12;
        end else begin
            dout_oe              <= 1'b1;
            conversion_strobe_oe <= 1'b1;
            if (rise && state_ff == sacs_pkg::SACS_CONV) begin
                conversion_strobe <= (cnt_ff == `SACS_STROBE_CNT);
                dout              <= 1'b0;
                if (cnt_ff == `SACS_STROBE_CNT) begin
                    dac_ff <= `SACS_MSB_TRIAL;
                end
                if (cnt_ff >= `SACS_MSB_CNT && cnt_ff <= `SACS_LSB_CNT) begin
                    // comparator high means the trial overshot, so the bit clears
                    dout            <= ~cmp_s;
                    dac_ff[bit_idx] <= ~cmp_s;
                    if (bit_idx != 4'h0) begin
                        dac_ff[bit_idx - 4'h1] <= 1'b1;
                    end
                end
            end else if (rise) begin
                conversion_strobe <= 1'b0;
                dout              <= 1'b0;
            end
        end
    end

    // packed in the struct's own field order; every field comes straight from a flop
    assign analog_ctrl = {pos_sel_ff, neg_sel_ff, neg_com_ff, track_ff, hold_ff, dac_ff};

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    start_shift_a: assert property (rise && active && state_ff == sacs_pkg::SACS_WAIT_START && din_s
        |=> cnt_ff == 5'h01 && state_ff == sacs_pkg::SACS_CTRL)
        else $error("start bit not taken");
    deselect_reset_a: assert property (!active |=> state_ff == sacs_pkg::SACS_WAIT_START && cnt_ff == 5'h00)
        else $error("shift logic not reset on deselect");
    dout_edge_a: assert property ($changed(dout) |-> $past(rise) || !$past(active))
        else $error("data output moved off a serial clock rise");
    float_out_a: assert property (!active |=> !dout_oe && !conversion_strobe_oe)
        else $error("outputs driven while deselected");
    strobe_pos_a: assert property ($rose(conversion_strobe) |-> cnt_ff == `SACS_MSB_CNT
        ##1 (conversion_strobe && cnt_ff == `SACS_MSB_CNT)[*1] ##0 !dout_oe || cnt_ff == `SACS_MSB_CNT)
        else $error("strobe at wrong position");
    strobe_width_a: assert property ($fell(conversion_strobe) |-> cnt_ff == 5'h0B || !$past(active))
        else $error("strobe not exactly one period");
    shutdown_idle_a: assert property (!shutdown_n_n_s |=> !analog_ctrl.track && !analog_ctrl.hold_to_neg)
        else $error("conversion active in shutdown");
    diff_pair_a: assert property (analog_ctrl.hold_to_neg && !analog_ctrl.neg_com
        |-> analog_ctrl.pos_sel[2:1] == analog_ctrl.neg_sel[2:1] && analog_ctrl.pos_sel[0] != analog_ctrl.neg_sel[0])
        else $error("differential pair broken");
    acq_end_a: assert property (fall && active && cnt_ff == `SACS_CTRL_BITS
        && state_ff != sacs_pkg::SACS_WAIT_START |=> !analog_ctrl.track && analog_ctrl.hold_to_neg)
        else $error("acquisition did not end after last control bit");
    track_open_a: assert property (fall && active && state_ff != sacs_pkg::SACS_WAIT_START
        && cnt_ff == `SACS_TRACK_CNT |=> analog_ctrl.track)
        else $error("tracking did not start after fifth bit");
    sar_seed_a: assert property (rise && active && state_ff == sacs_pkg::SACS_CONV
        && cnt_ff == `SACS_STROBE_CNT |=> analog_ctrl.dac_code == `SACS_MSB_TRIAL)
        else $error("conversion did not start from the midscale trial");

endmodule

// >>> core/sacs_defines.svh
// constants of the serial conversion sequencer: bit counts and edge positions
// assumes one 20 MHz system clock that oversamples the serial clock pin
// Function
// - shift data in on serial clock rise
// - ignore data while chip select high
// - update data output on serial clock rise
// - data and strobe outputs floating when deselected
// - strobe high one period before MSB decision
// - shutdown input low suspends all conversion
// - single-ended: channel positive, common reference negative
// - differential pairs fixed: 0/1, 2/3, 4/5, 6/7
// - acquisition three periods, ends after last bit
// - hold sample, then switch capacitor to negative; the code does both on the same fall
// - twelve bits resolved MSB first
// - conversion spans fifteen serial clock periods
// - leading zeros ignored, first one starts byte
// - track after fifth bit, hold after eighth
// - sixteen clocks per conversion, chip select low; the sequencer takes 24 rises to reach SACS_DONE
// - result framed: three zeros, twelve bits, zero
`ifndef SACS_DEFINES_SVH
`define SACS_DEFINES_SVH
`define SACS_CTRL_BITS   5'h08
`define SACS_SEL_CNT     5'h03
`define SACS_TRACK_CNT   5'h05
`define SACS_SGL_CNT     5'h05
`define SACS_STROBE_CNT  5'h09
`define SACS_MSB_CNT     5'h0A
`define SACS_LSB_CNT     5'h15
`define SACS_LAST_CNT    5'h17
`define SACS_MSB_TRIAL   12'h800
`define SACS_ZERO12      12'h000
`endif

// >>> core/sacs_pkg.sv
// types of the serial conversion sequencer
// assumes sacs_defines.svh supplies the numeric constants
package sacs_pkg;
    typedef enum logic [1:0] {
        SACS_WAIT_START,
        SACS_CTRL,
        SACS_CONV,
        SACS_DONE
    } sacs_state_t;

    // controls toward the analog front end
    typedef struct packed {
        logic [2:0]  pos_sel;
        logic [2:0]  neg_sel;
        logic        neg_com;
        logic        track;
        logic        hold_to_neg;
        logic [11:0] dac_code;
    } sacs_analog_t;
endpackage

// >>> sim/sacs_master_model.sv
// serial master model: drives chip select, serial clock and data in, mode 0
// assumes clk is the 20 MHz bench clock; every change lands just after its falling edge
`timescale 1ns/1ps
module sacs_master_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      din
);
    int rn;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
        rn   = 0;
    end
    // one serial period: 4 clk low, 4 clk high, a 50 percent duty
    task automatic tick(input logic b);
        din = b;
        repeat (4) @(negedge clk);
        rn++;
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
    endtask
    // leading zeros, control byte, then zeros up to n rises counted from the start bit
    task automatic frame(input logic [7:0] ctrl, input int lead, input int n);
        cs_n = 1'b0;
        rn = -lead;
        repeat (lead) tick(1'b0);
        for (int i = 7; i >= 0; i--) tick(ctrl[i]);
        repeat (n - 8) tick(1'b0);
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // released line: show the inverse so a stale value is never trusted
        din = ~din;
        // the deselect must be seen before a following frame pulls chip select low again
        repeat (6) @(negedge clk);
    endtask
endmodule

// >>> sim/sacs_top_tb.sv
// self-checking bench of the conversion sequencer with a serial master model
// assumes the comparator is modelled here against a target code per conversion
`timescale 1ns/1ps
module sacs_top_tb;
    logic                   clk, resetn, shutdown_n, comparator;
    logic                   dout, dout_oe, conversion_strobe, conversion_strobe_oe;
    logic                   sclk, cs_n, din;
    sacs_pkg::sacs_analog_t analog_ctrl, a_s;
    logic [23:0]            d_s, s_s, t_s, h_s;
    logic                   oe_s;
    logic [11:0]            tgt;
    int                     num_errors, n_checks;

    sacs_master_model m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din));
    sacs_top uut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
        .shutdown_n(shutdown_n), .comparator(comparator), .dout(dout), .dout_oe(dout_oe),
        .conversion_strobe(conversion_strobe), .conversion_strobe_oe(conversion_strobe_oe),
        .analog_ctrl(analog_ctrl));

    initial clk = 1'b0;
    always #25 clk = ~clk;
    // comparator: 1 while the trial code is above the input, so the result settles on tgt
    always @(negedge clk) comparator <= (analog_ctrl.dac_code > tgt);
    // snapshot of the outputs at each serial rise from rise 1 on, rise 1 is the start bit
    always @(posedge sclk) begin
        if (m.rn >= 1) begin
            d_s = {d_s[22:0], dout};
            s_s = {s_s[22:0], conversion_strobe};
            t_s = {t_s[22:0], analog_ctrl.track};
            h_s = {h_s[22:0], analog_ctrl.hold_to_neg};
            if (m.rn == 12) begin
                a_s = analog_ctrl;
                oe_s = dout_oe & conversion_strobe_oe;
            end
        end
    end

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one full conversion, judged bit by bit against the frame timing
    task automatic frame_chk(input logic [7:0] c, input int lead, input logic [2:0] ep, en, input logic ec);
        m.frame(c, lead, 24);
        chk(d_s[15:0] === {3'b000, tgt, 1'b0}, "result");
        chk(s_s === 24'h00_2000, "strobe");
        chk(h_s === 24'h00_FFFE, "hold span");
        chk((t_s & 24'hFF_FFFE) === 24'h07_0000, "track span");
        chk(oe_s === 1'b1, "enables");
        chk(a_s.pos_sel === ep && a_s.neg_com === ec && (ec || a_s.neg_sel === en), "mux");
    endtask
    task automatic t_single();
        for (int c = 0; c < 8; c++) begin
            tgt = (c == 0) ? 12'h000 : (c == 7) ? 12'hFFF : 12'h1A5 + 12'h1F3 * c;
            frame_chk({1'b1, c[2:0], 4'b1111}, c % 3, c[2:0], 3'h0, 1'b1);
        end
        $display("single-ended test done");
    endtask
    task automatic t_diff();
        for (int c = 0; c < 8; c++) begin
            tgt = 12'h0A5 + 12'h200 * c;
            frame_chk({1'b1, c[2:0], 4'b1011}, 1, c[2:0], c[2:0] ^ 3'h1, 1'b0);
        end
        $display("differential test done");
    endtask
    task automatic t_abort();
        tgt = 12'h5A3;
        m.frame(8'h8F, 0, 10);
        repeat (6) @(negedge clk);
        chk(dout_oe === 1'b0 && conversion_strobe_oe === 1'b0, "float");
        chk(analog_ctrl.hold_to_neg === 1'b0, "abort");
        m.din = 1'b1; // data high with chip select high must start nothing
        repeat (10) @(negedge clk);
        chk(dout_oe === 1'b0 && analog_ctrl.track === 1'b0, "deselected");
        frame_chk(8'hCF, 2, 3'h4, 3'h0, 1'b1);
        $display("abort test done");
    endtask
    task automatic t_shutdown_n();
        tgt = 12'h3C3;
        fork
            m.frame(8'hFF, 0, 24);
            begin
                repeat (90) @(negedge clk);
                shutdown_n = 1'b0;
                repeat (6) @(negedge clk);
                chk(dout_oe === 1'b0 && analog_ctrl.hold_to_neg === 1'b0, "shutdown");
            end
        join
        shutdown_n = 1'b1;
        repeat (6) @(negedge clk);
        frame_chk(8'hFF, 0, 3'h7, 3'h0, 1'b1);
        $display("shutdown test done");
    endtask

    initial begin
        resetn = 1'b0;
        shutdown_n = 1'b1;
        comparator = 1'b0;
        tgt = 12'h000;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        t_single();
        t_diff();
        t_abort();
        t_shutdown_n();
        end_of_test();
    end
    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("ERROR %0t timeout", $time);
        end_of_test();
    end
endmodule
